// *** verilog/usb_ep_params.svh ***
`ifndef USB_EP_PARAMS_SVH
`define USB_EP_PARAMS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_EP0_COUNT 12'h040
`define OFS_EP0_MODE  12'h044
`define OFS_EP1_MODE  12'h048
`define OFS_EP2_MODE  12'h04c
`define OFS_INT_STAT  12'h050
`define OFS_INT_MASK  12'h054
// ****************************************************************
// reset values and field positions
// ****************************************************************
`define RST_REG8      8'h00
`define RST_INT       5'h00
`define FLAG_SETUP    7
`define FLAG_ACKED    4
`define INT_BITS      5
`endif

// *** verilog/usb_ep_pkg.sv ***
`default_nettype none
package usb_ep_pkg;
  // ****************************************************************
  // endpoint response modes
  // ****************************************************************
  typedef enum logic [3:0] {
    MODE_DISABLE = 4'b0000,
    MODE_NAK_OUT = 4'b1000,
    MODE_ACK_OUT = 4'b1001,
    MODE_NAK_IN  = 4'b1100,
    MODE_ACK_IN  = 4'b1101
  } mode_type;

  // engine register write strobe with its data
  typedef struct packed {
    logic       en;
    logic [7:0] data;
  } eng_write_type;

  // endpoint 0 transaction events, one-cycle pulses
  typedef struct packed {
    logic setup;
    logic in_rx;
    logic out_rx;
    logic acked;
  } ep0_event_type;

  // data endpoint mode register layout
  typedef struct packed {
    logic       stall;
    logic       spare;
    logic       nak_int_en;
    logic       acked;
    logic [3:0] mode;
  } data_mode_type;
endpackage : usb_ep_pkg
`default_nettype wire

// *** verilog/usb_endpoint_mode_interlock.sv ***
// Decided for this implementation: register access over APB.
`include "usb_ep_params.svh"
`default_nettype none
module usb_endpoint_mode_interlock #(
  parameter int ADDR_W = 12
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  input  wire usb_ep_pkg::eng_write_type    ep0_mode_wr,
  input  wire usb_ep_pkg::eng_write_type    ep0_count_wr,
  input  wire usb_ep_pkg::ep0_event_type    ep0_event,
  input  wire usb_ep_pkg::eng_write_type [1:0] data_mode_wr,
  input  wire logic [1:0]                   ack_out_sent,
  input  wire logic [1:0]                   ack_in_rcvd,
  input  wire logic [1:0]                   nak_sent,
  output logic [7:0]                        ep0_mode_status,
  output logic [7:0]                        ep0_count,
  output usb_ep_pkg::data_mode_type [1:0]   data_mode,
  output logic [2:0]                        ep_enabled,
  output logic                              irq
);
  import usb_ep_pkg::*;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic                 wr;
  logic                 rd;
  logic                 lock_mode;
  logic                 lock_count;
  logic                 upd;
  logic [3:0]           ev0;
  logic [1:0]           ev_ack;
  logic [1:0]           ev_nak;
  logic [`INT_BITS-1:0] int_stat;
  logic [`INT_BITS-1:0] int_mask;
  logic [`INT_BITS-1:0] ev_int;
  logic [`INT_BITS-1:0] w1c;

  // a transfer completes at the single edge with pready high
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;

  // pready rises one cycle after setup: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `OFS_EP0_COUNT: prdata[7:0] <= ep0_count;
          `OFS_EP0_MODE:  prdata[7:0] <= ep0_mode_status;
          `OFS_EP1_MODE:  prdata[7:0] <= data_mode[0];
          `OFS_EP2_MODE:  prdata[7:0] <= data_mode[1];
          `OFS_INT_STAT:  prdata[`INT_BITS-1:0] <= int_stat;
          `OFS_INT_MASK:  prdata[`INT_BITS-1:0] <= int_mask;
          default:        pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        unique case (paddr)
          `OFS_EP0_COUNT, `OFS_EP0_MODE, `OFS_EP1_MODE,
          `OFS_EP2_MODE, `OFS_INT_STAT, `OFS_INT_MASK: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // endpoint 0 interlock
  // ****************************************************************
  // lock each endpoint 0 register
  // cpu read unlocks, the engine lock wins a tie
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_mode  <= 1'b0;
      lock_count <= 1'b0;
    end else begin
      if (ep0_mode_wr.en)
        lock_mode <= 1'b1;
      else if (rd && paddr == `OFS_EP0_MODE)
        lock_mode <= 1'b0;
      if (ep0_count_wr.en)
        lock_count <= 1'b1;
      else if (rd && paddr == `OFS_EP0_COUNT)
        lock_count <= 1'b0;
    end
  end

  assign ev0 = (ep0_mode_status[3:0] == MODE_DISABLE) ? 4'h0 :
               {ep0_event.setup, ep0_event.in_rx,
                ep0_event.out_rx, ep0_event.acked};

  // events set flags and win over a clearing write
  // accepted cpu write clears the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep0_mode_status <= `RST_REG8;
    end else if (ep0_mode_wr.en) begin
      ep0_mode_status <= ep0_mode_wr.data | {ev0, 4'h0};
    end else if (wr && paddr == `OFS_EP0_MODE && !lock_mode) begin
      ep0_mode_status <= {ev0, pwdata[3:0]};
    end else begin
      ep0_mode_status[7:4] <= ep0_mode_status[7:4] | ev0;
    end
  end

  // a locked count ignores cpu writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ep0_count <= `RST_REG8;
    else if (ep0_count_wr.en)
      ep0_count <= ep0_count_wr.data;
    else if (wr && paddr == `OFS_EP0_COUNT && !lock_count)
      ep0_count <= pwdata[7:0];
  end

  // ****************************************************************
  // data endpoints 1 and 2
  // ****************************************************************
  // one shared update strobe, so either engine write blocks both
  assign upd = data_mode_wr[0].en || data_mode_wr[1].en;

  for (genvar i = 0; i < 2; i++) begin : g_ep
    logic ack_out;
    logic ack_in;
    logic fw;
    // mode 0000 never matches an ack mode, so events drop
    assign ack_out = ack_out_sent[i] && data_mode[i].mode == MODE_ACK_OUT;
    assign ack_in  = ack_in_rcvd[i] && data_mode[i].mode == MODE_ACK_IN;
    assign ev_ack[i] = ack_out || ack_in;
    assign ev_nak[i] = nak_sent[i] && data_mode[i].nak_int_en &&
                       data_mode[i].mode != MODE_DISABLE;
    // engine write wins, firmware write blocked
    assign fw = wr && !upd && paddr == (`OFS_EP1_MODE + 12'(4 * i));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        data_mode[i] <= `RST_REG8;
      end else if (data_mode_wr[i].en) begin
        data_mode[i] <= data_mode_wr[i].data;
      end else if (fw) begin
        // any firmware write clears acked, a same-cycle ack sets it
        data_mode[i] <= {pwdata[7:5], ev_ack[i], pwdata[3:0]};
      end else begin
        if (ev_ack[i])
          data_mode[i].acked <= 1'b1;
        if (ack_out)
          data_mode[i].mode <= MODE_NAK_OUT;
        if (ack_in)
          data_mode[i].mode <= MODE_NAK_IN;
      end
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign ev_int = {ev_nak, ev_ack, |ev0};
  assign w1c = (wr && paddr == `OFS_INT_STAT) ?
               pwdata[`INT_BITS-1:0] : `RST_INT;

  // sticky status, write one to clear, a new event wins the tie
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= `RST_INT;
      int_mask <= `RST_INT;
      irq      <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~w1c) | ev_int;
      if (wr && paddr == `OFS_INT_MASK)
        int_mask <= pwdata[`INT_BITS-1:0];
      irq <= |(int_stat & int_mask);
    end
  end

  // registered copy keeps the engine's ignore decision glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ep_enabled <= 3'b000;
    else
      ep_enabled <= {data_mode[1].mode != MODE_DISABLE,
                     data_mode[0].mode != MODE_DISABLE,
                     ep0_mode_status[3:0] != MODE_DISABLE};
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence eng_ep1_cpu_ep2;
    data_mode_wr[0].en && !data_mode_wr[1].en && wr &&
    paddr == `OFS_EP2_MODE;
  endsequence
  sequence ep2_quiet;
    !ev_ack[1];
  endsequence

  lock_on_engine_a: assert property (
    ep0_mode_wr.en |=> lock_mode ##0 ep0_mode_status == $past(
      ep0_mode_wr.data | {ev0, 4'h0}))
    else $error("engine write did not lock mode register");
  cpu_write_blocked_a: assert property (
    lock_mode && !ep0_mode_wr.en && wr && paddr == `OFS_EP0_MODE
    |=> $stable(ep0_mode_status[3:0]))
    else $error("locked mode register took a cpu write");
  read_unlocks_a: assert property (
    rd && paddr == `OFS_EP0_MODE && !ep0_mode_wr.en |=> !lock_mode)
    else $error("read did not unlock mode register");
  count_interlock_a: assert property (
    lock_count && !ep0_count_wr.en && wr && paddr == `OFS_EP0_COUNT
    |=> $stable(ep0_count))
    else $error("locked count register took a cpu write");
  flag_clear_a: assert property (
    wr && paddr == `OFS_EP0_MODE && !lock_mode && !ep0_mode_wr.en &&
    ev0 == 4'h0 |=> ep0_mode_status[7:4] == 4'h0)
    else $error("cpu write left flags set");
  setup_flag_a: assert property (
    ev0[3] && !ep0_mode_wr.en |=> ep0_mode_status[`FLAG_SETUP])
    else $error("setup event not flagged");
  engine_wins_a: assert property (
    eng_ep1_cpu_ep2 ##0 ep2_quiet |=> $stable(data_mode[1]))
    else $error("cpu write passed a same-cycle engine write");
  ack_out_switch_a: assert property (
    g_ep[0].ack_out && !data_mode_wr[0].en && !g_ep[0].fw
    |=> data_mode[0].mode == MODE_NAK_OUT && data_mode[0].acked)
    else $error("ack-out mode did not fall back");
  ack_in_switch_a: assert property (
    g_ep[1].ack_in && !data_mode_wr[1].en && !g_ep[1].fw
    |=> data_mode[1].mode == MODE_NAK_IN && data_mode[1].acked)
    else $error("ack-in mode did not fall back");
  disabled_quiet_a: assert property (
    ep0_mode_status[3:0] == MODE_DISABLE && !ep0_mode_wr.en &&
    !(wr && paddr == `OFS_EP0_MODE) |=> $stable(ep0_mode_status))
    else $error("disabled endpoint changed on an event");
endmodule : usb_endpoint_mode_interlock
`default_nettype wire

// *** tb/usb_engine_model.sv ***
`default_nettype none
module usb_engine_model (
  input  wire logic                             pclk,
  output usb_ep_pkg::eng_write_type             ep0_mode_wr,
  output usb_ep_pkg::eng_write_type             ep0_count_wr,
  output usb_ep_pkg::ep0_event_type             ep0_event,
  output usb_ep_pkg::eng_write_type [1:0]       data_mode_wr,
  output logic [1:0]                            ack_out_sent,
  output logic [1:0]                            ack_in_rcvd,
  output logic [1:0]                            nak_sent
);
  timeunit 1ns;
  timeprecision 1ns;
  import usb_ep_pkg::*;
  // ****************************************************************
  // protocol engine strobes, one-cycle pulses
  // ****************************************************************
  initial begin
    ep0_mode_wr = '0;
    ep0_count_wr = '0;
    ep0_event = '0;
    data_mode_wr = '0;
    ack_out_sent = '0;
    ack_in_rcvd = '0;
    nak_sent = '0;
  end
  // called just after an edge; data flips once the strobe drops
  // an idle edge follows, so back to back pulses never reassign a
  // strobe within one time step
  task automatic pulse(input int k, input int i, input logic [7:0] d);
    case (k)
      0: ep0_mode_wr <= '{1'h1, d};
      1: ep0_count_wr <= '{1'h1, d};
      2: ep0_event[i] <= 1'h1;
      3: ack_out_sent[i] <= 1'h1;
      4: ack_in_rcvd[i] <= 1'h1;
      5: nak_sent[i] <= 1'h1;
      default: data_mode_wr[i] <= '{1'h1, d};
    endcase
    @(posedge pclk);
    ep0_mode_wr <= '{1'h0, ~d};
    ep0_count_wr <= '{1'h0, ~d};
    data_mode_wr <= {2{1'h0, ~d}};
    ep0_event <= '0;
    ack_out_sent <= '0;
    ack_in_rcvd <= '0;
    nak_sent <= '0;
    @(posedge pclk);
  endtask : pulse
endmodule : usb_engine_model
`default_nettype wire

// *** tb/usb_endpoint_mode_interlock_tb.sv ***
`include "usb_ep_params.svh"
`default_nettype none
module usb_endpoint_mode_interlock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import usb_ep_pkg::*;
  logic                   pclk = 1'h0;
  logic                   presetn = 1'h0;
  logic                   psel = 1'h0;
  logic                   penable = 1'h0;
  logic                   pwrite = 1'h0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0;
  logic                   pready, pslverr, irq, last_err;
  logic [31:0]            prdata;
  eng_write_type          ep0_mode_wr, ep0_count_wr;
  eng_write_type [1:0]    data_mode_wr;
  ep0_event_type          ep0_event;
  logic [1:0]             ack_out_sent, ack_in_rcvd, nak_sent;
  logic [7:0]             ep0_mode_status, ep0_count;
  data_mode_type [1:0]    data_mode;
  logic [2:0]             ep_enabled;
  int                     num_errors = 0;
  int                     checks = 0;

  // 10 MHz clock
  always #50 pclk = ~pclk;

  usb_endpoint_mode_interlock dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ep0_mode_wr(ep0_mode_wr), .ep0_count_wr(ep0_count_wr),
    .ep0_event(ep0_event), .data_mode_wr(data_mode_wr),
    .ack_out_sent(ack_out_sent), .ack_in_rcvd(ack_in_rcvd),
    .nak_sent(nak_sent), .ep0_mode_status(ep0_mode_status),
    .ep0_count(ep0_count), .data_mode(data_mode),
    .ep_enabled(ep_enabled), .irq(irq));
  usb_engine_model eng_u (.pclk(pclk), .ep0_mode_wr(ep0_mode_wr),
    .ep0_count_wr(ep0_count_wr), .ep0_event(ep0_event),
    .data_mode_wr(data_mode_wr), .ack_out_sent(ack_out_sent),
    .ack_in_rcvd(ack_in_rcvd), .nak_sent(nak_sent));

  // ****************************************************************
  // checking and apb master tasks
  // ****************************************************************
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // request held until pready is seen; an idle edge avoids re-entry races
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      num_errors++;
      end_sim();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    apb(1'h1, a, d, q);
  endtask : wr
  task automatic rd(input string n, logic [11:0] a, logic [31:0] e);
    logic [31:0] q;
    apb(1'h0, a, 32'h0, q);
    chk(n, e, q);
  endtask : rd

  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd("ep0_mode", `OFS_EP0_MODE, 32'h00);
    rd("ep1_mode", `OFS_EP1_MODE, 32'h00);
    eng_u.pulse(0, 0, 8'h01);
    wr(`OFS_EP0_MODE, 32'h02);
    rd("ep0_mode", `OFS_EP0_MODE, 32'h01);
    wr(`OFS_EP0_MODE, 32'h02);
    rd("ep0_mode", `OFS_EP0_MODE, 32'h02);
    eng_u.pulse(1, 0, 8'h05);
    wr(`OFS_EP0_COUNT, 32'h07);
    rd("ep0_count", `OFS_EP0_COUNT, 32'h05);
    wr(`OFS_EP0_COUNT, 32'h07);
    rd("ep0_count", `OFS_EP0_COUNT, 32'h07);
    for (int i = 0; i < 4; i++) eng_u.pulse(2, i, 8'h00);
    rd("ep0_flags", `OFS_EP0_MODE, 32'hf2);
    wr(`OFS_EP0_MODE, 32'hf3);
    rd("ep0_mode", `OFS_EP0_MODE, 32'h03);
    wr(`OFS_EP0_MODE, 32'h00);
    eng_u.pulse(2, 3, 8'h00);
    rd("ep0_off", `OFS_EP0_MODE, 32'h00);
    wr(`OFS_INT_STAT, 32'h1f);
    wr(`OFS_EP1_MODE, 32'h09);
    eng_u.pulse(3, 0, 8'h00);
    rd("ep1_mode", `OFS_EP1_MODE, 32'h18);
    wr(`OFS_EP2_MODE, 32'h0d);
    eng_u.pulse(4, 1, 8'h00);
    rd("ep2_mode", `OFS_EP2_MODE, 32'h1c);
    wr(`OFS_EP1_MODE, 32'h28);
    eng_u.pulse(5, 0, 8'h00);
    rd("int_stat", `OFS_INT_STAT, 32'h0e);
    chk("irq", 32'h0, 32'(irq));
    wr(`OFS_INT_MASK, 32'h08);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    wr(`OFS_INT_STAT, 32'h08);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    rd("int_stat", `OFS_INT_STAT, 32'h06);
    rd("unmapped", 12'h0f0, 32'h0);
    chk("pslverr", 32'h1, 32'(last_err));
    wr(`OFS_EP2_MODE, 32'h0c);
    fork
      wr(`OFS_EP2_MODE, 32'h0d);
      begin
        @(posedge pclk);
        eng_u.pulse(6, 0, 8'h08);
      end
    join
    rd("ep1_mode", `OFS_EP1_MODE, 32'h08);
    rd("ep2_mode", `OFS_EP2_MODE, 32'h0c);
    chk("ep_outputs", 32'h0c08_0007,
        {data_mode, ep0_mode_status, ep0_count});
    chk("ep_enabled", 32'h6, 32'(ep_enabled));
    end_sim();
  end
endmodule : usb_endpoint_mode_interlock_tb
`default_nettype wire
